/* File: dv/tb_supply_voltage_monitor.sv */
// Self-checking bench for the supply voltage monitor register block
`timescale 1ns/100ps

module tb_supply_voltage_monitor;
   import svm_pkg::*;

   logic                  clk_sys;
   logic                  arst_n;
   logic [SVM_ADDR_W-1:0] avs_address;
   logic                  avs_read;
   logic                  avs_write;
   logic [SVM_DATA_W-1:0] avs_writedata;
   logic [SVM_DATA_W-1:0] avs_readdata;
   logic                  avs_waitrequest;
   logic                  cmpBelow;
   logic                  detectorOn;
   logic                  referenceOn;
   logic [SVM_THR_W-1:0]  thresholdSel;
   logic                  lowSupplyIrqFlag;
   logic                  wakeReq;
   logic                  irq;
   int                    errors;
   int                    totalChecks;
   int                    wakeCount;

   svm_top svm_top_inst (
      .clk_sys          (clk_sys),
      .arst_n           (arst_n),
      .avs_address      (avs_address),
      .avs_read         (avs_read),
      .avs_write        (avs_write),
      .avs_writedata    (avs_writedata),
      .avs_readdata     (avs_readdata),
      .avs_waitrequest  (avs_waitrequest),
      .cmpBelow         (cmpBelow),
      .detectorOn       (detectorOn),
      .referenceOn      (referenceOn),
      .thresholdSel     (thresholdSel),
      .lowSupplyIrqFlag (lowSupplyIrqFlag),
      .wakeReq          (wakeReq),
      .irq              (irq)
   );

   always #2 clk_sys = ~clk_sys;

   // Wake pulses last one cycle, so count them on every rising edge
   always @(posedge clk_sys) begin
      if (wakeReq === 1'b1) wakeCount <= wakeCount + 1;
   end

   ////////////////////////////////////////////////////////////////////////////
   task automatic print_verdict();
      if (errors == 0 && totalChecks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      totalChecks++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Request held until waitrequest is sampled low at a rising edge; watchdog ends a hang
   task automatic access(input logic wr, input logic [3:0] a, input logic [31:0] d,
                         output logic [31:0] q);
      @(posedge clk_sys);
      avs_address   <= a;
      avs_write     <= wr;
      avs_read      <= ~wr;
      avs_writedata <= d;
      do begin
         @(posedge clk_sys);
      end while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_read  <= 1'b0;
      avs_write <= 1'b0;
   endtask

   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      logic [31:0] q;
      access(1'b1, a, d, q);
   endtask

   task automatic rdchk(input logic [3:0] a, input logic [31:0] exp);
      logic [31:0] q;
      access(1'b0, a, 32'h0, q);
      chk(q, exp);
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask

   task automatic setCmp(input logic v);
      @(posedge clk_sys);
      cmpBelow <= v;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (20000) @(posedge clk_sys);
      errors++;
      $display("CHECK FAILED at %0t: run too long", $time);
      print_verdict();
   end

   initial begin
      int n;
      clk_sys = 1'b0;
      arst_n = 1'b0;
      avs_address = 4'h0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0;
      cmpBelow = 1'b0;
      errors = 0;
      totalChecks = 0;
      wakeCount = 0;
      repeat (8) @(posedge clk_sys);
      arst_n <= 1'b1;
      cyc(1);
      chk(32'({detectorOn, referenceOn, thresholdSel, lowSupplyIrqFlag, irq}), 32'h0);
      rdchk(SVM_CTRL_OFFSET, 32'h0);
      rdchk(SVM_STAT_OFFSET, 32'h0);
      rdchk(SVM_MASK_OFFSET, 32'h0);
      wr(SVM_CTRL_OFFSET, 32'hffff_ffff);
      rdchk(SVM_CTRL_OFFSET, 32'h17);
      chk(32'({detectorOn, referenceOn, thresholdSel}), 32'h1f);
      wr(4'h2, 32'hffff_ffff);
      rdchk(4'h2, 32'h0);
      rdchk(SVM_CTRL_OFFSET, 32'h17);
      // Only codes inside the usable detection range
      for (int t = 3; t <= 7; t++) begin
         wr(SVM_CTRL_OFFSET, 32'h10 | 32'(t));
         cyc(2);
         chk(32'(thresholdSel), 32'(t));
      end
      wr(SVM_CTRL_OFFSET, 32'h13);
      setCmp(1'b1);
      cyc(5);
      rdchk(SVM_CTRL_OFFSET, 32'h33);
      setCmp(1'b0);
      cyc(5);
      rdchk(SVM_CTRL_OFFSET, 32'h13);
      // A dip before the delay runs out must restart it
      setCmp(1'b1);
      cyc(150);
      setCmp(1'b0);
      cyc(10);
      setCmp(1'b1);
      cyc(150);
      chk(32'(lowSupplyIrqFlag), 32'h0);
      cyc(90);
      chk(32'(lowSupplyIrqFlag), 32'h0);
      n = 0;
      while (lowSupplyIrqFlag !== 1'b1 && n < 30) begin
         cyc(1);
         n++;
      end
      chk(32'(lowSupplyIrqFlag), 32'h1);
      cyc(2);
      chk(32'(wakeCount), 32'h1);
      chk(32'(irq), 32'h0);
      rdchk(SVM_STAT_OFFSET, 32'h1);
      wr(SVM_MASK_OFFSET, 32'h1);
      cyc(2);
      chk(32'(irq), 32'h1);
      setCmp(1'b0);
      wr(SVM_STAT_OFFSET, 32'h1);
      cyc(2);
      chk(32'(irq), 32'h0);
      rdchk(SVM_STAT_OFFSET, 32'h0);
      // Software preset of the flag must not wake
      wr(SVM_FORCE_OFFSET, 32'h1);
      cyc(2);
      chk(32'({lowSupplyIrqFlag, irq}), 32'h3);
      chk(32'(wakeCount), 32'h1);
      wr(SVM_STAT_OFFSET, 32'h1);
      setCmp(1'b1);
      wr(SVM_CTRL_OFFSET, 32'h3);
      cyc(5);
      rdchk(SVM_CTRL_OFFSET, 32'h3);
      chk(32'({detectorOn, referenceOn}), 32'h0);
      print_verdict();
   end

endmodule // tb_supply_voltage_monitor

/* File: hw/svm_lib.sv */
// Synchroniser and delay timer used by the supply voltage monitor
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////////
module svm_sync
   import svm_pkg::*;
(
   // Clock and reset
   input  wire logic clk_sys,
   input  wire logic arst_n,
   // Data
   input  wire logic asyncIn,
   output logic      syncOut
);

   logic metaReg;

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         metaReg <= 1'b0;
         syncOut <= 1'b0;
      end else begin
         metaReg <= asyncIn;
         syncOut <= metaReg;
      end
   end

endmodule // svm_sync

////////////////////////////////////////////////////////////////////////////////
module svm_delay
   import svm_pkg::*;
(
   // Clock and reset
   input  wire logic clk_sys,
   input  wire logic arst_n,
   // Control
   input  wire logic run,
   output logic      expired
);

   logic [SVM_DLY_W-1:0] countReg;

   // One pulse per run period; a drop of run restarts the wait
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         countReg <= '0;
         expired  <= 1'b0;
      end else if (!run) begin
         countReg <= '0;
         expired  <= 1'b0;
      end else if (countReg < SVM_DLY_W'(SVM_IRQ_DELAY_CYC)) begin
         countReg <= countReg + SVM_DLY_W'(1);
         expired  <= (countReg == SVM_DLY_W'(SVM_IRQ_DELAY_CYC - 1));
      end else begin
         expired  <= 1'b0;
      end
   end

endmodule // svm_delay

/* File: hw/svm_pkg.sv */
// Constants shared by the supply voltage monitor design
package svm_pkg;

   // Bus geometry
   localparam int          SVM_ADDR_W        = 4;
   localparam int          SVM_DATA_W        = 32;

   // Register byte addresses
   localparam logic [3:0]  SVM_CTRL_OFFSET   = 4'h0;
   localparam logic [3:0]  SVM_STAT_OFFSET   = 4'h4;
   localparam logic [3:0]  SVM_MASK_OFFSET   = 4'h8;
   localparam logic [3:0]  SVM_FORCE_OFFSET  = 4'hc;

   // Control register fields
   localparam int          SVM_THR_LSB       = 0;
   localparam int          SVM_THR_W         = 3;
   localparam int          SVM_EN_BIT        = 4;
   localparam int          SVM_LOW_BIT       = 5;
   localparam int          SVM_CTRL_W        = 8;

   // Interrupt status / mask / force fields
   localparam int          SVM_FLAG_BIT      = 0;

   // Reset values
   localparam logic [2:0]  SVM_THR_RST       = 3'h0;
   localparam logic        SVM_EN_RST        = 1'b0;
   localparam logic        SVM_FLAG_RST      = 1'b0;
   localparam logic        SVM_MASK_RST      = 1'b0;

   // Threshold codes: lowest level up to the top level at 4.0 V
   localparam logic [2:0]  SVM_THR_MIN       = 3'h0;
   localparam logic [2:0]  SVM_THR_MAX       = 3'h7;

   // Interrupt assertion delay after the low status rises
   localparam int          SVM_CLK_PERIOD_NS = 4;
   localparam int          SVM_IRQ_DELAY_NS  = 1000;
   localparam int          SVM_IRQ_DELAY_CYC =
      (SVM_IRQ_DELAY_NS + SVM_CLK_PERIOD_NS - 1) / SVM_CLK_PERIOD_NS;
   localparam int          SVM_DLY_W         = 10;

endpackage

/* File: hw/svm_top.sv */
// Supply voltage monitor: control register, status, delayed interrupt flag
// Function
// - Status bit high while supply below threshold
// - Enable bit switches detector on or off
// - Three-bit code selects level, 111 is 4.0V
// - Reference enabled automatically with the detector
// - Status toggles pass through, never latched
// - Interrupt after fixed delay past rise, or at once when software presets the flag
// - Delay expiry sets the interrupt request flag
// - Hardware setting of the flag wakes from sleep and idle; a software preset gives no wake
`timescale 1ns/100ps

module svm_top
   import svm_pkg::*;
(
   // Clock and reset
   input  wire logic                  clk_sys,
   input  wire logic                  arst_n,
   // Avalon-MM slave
   input  wire logic [SVM_ADDR_W-1:0] avs_address,
   input  wire logic                  avs_read,
   input  wire logic                  avs_write,
   input  wire logic [SVM_DATA_W-1:0] avs_writedata,
   output logic      [SVM_DATA_W-1:0] avs_readdata,
   output logic                       avs_waitrequest,
   // Analog comparator side
   input  wire logic                  cmpBelow,
   output logic                       detectorOn,
   output logic                       referenceOn,
   output logic      [SVM_THR_W-1:0]  thresholdSel,
   // Interrupt and wake
   output logic                       lowSupplyIrqFlag,
   output logic                       wakeReq,
   output logic                       irq
);

   ////////////////////////////////////////////////////////////////////////////
   // Bus decode
   logic                 busReq;
   logic                 busAck;
   logic                 wrCtrl;
   logic                 wrStat;
   logic                 wrMask;
   logic                 wrForce;
   logic                 enable_reg;
   logic [SVM_THR_W-1:0] threshold_reg;
   logic                 lowStatus_reg;
   logic                 flag_reg;
   logic                 mask_reg;
   logic                 cmpSync;
   logic                 delayExpired;
   logic [SVM_DATA_W-1:0] readdata_next;

   assign busReq  = avs_read | avs_write;
   assign busAck  = busReq & ~avs_waitrequest;
   assign wrCtrl  = busAck & avs_write & (avs_address == SVM_CTRL_OFFSET);
   assign wrStat  = busAck & avs_write & (avs_address == SVM_STAT_OFFSET);
   assign wrMask  = busAck & avs_write & (avs_address == SVM_MASK_OFFSET);
   assign wrForce = busAck & avs_write & (avs_address == SVM_FORCE_OFFSET);

   // One wait cycle, then a single-cycle answer
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         avs_waitrequest <= 1'b1;
      end else begin
         avs_waitrequest <= ~(busReq & avs_waitrequest);
      end
   end

   always_comb begin
      readdata_next = '0;
      case (avs_address)
         SVM_CTRL_OFFSET: begin
            readdata_next[SVM_THR_LSB +: SVM_THR_W] = threshold_reg;
            readdata_next[SVM_EN_BIT]               = enable_reg;
            readdata_next[SVM_LOW_BIT]              = lowStatus_reg;
         end
         SVM_STAT_OFFSET: readdata_next[SVM_FLAG_BIT] = flag_reg;
         SVM_MASK_OFFSET: readdata_next[SVM_FLAG_BIT] = mask_reg;
         default:         readdata_next = '0;
      endcase
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         avs_readdata <= '0;
      end else if (busReq & avs_waitrequest & avs_read) begin
         avs_readdata <= readdata_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Control register
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         enable_reg    <= SVM_EN_RST;
         threshold_reg <= SVM_THR_RST;
      end else if (wrCtrl) begin
         enable_reg    <= avs_writedata[SVM_EN_BIT];
         threshold_reg <= avs_writedata[SVM_THR_LSB +: SVM_THR_W];
      end
   end

   // Analog side follows the register; reference tied to detector power
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         detectorOn   <= 1'b0;
         referenceOn  <= 1'b0;
         thresholdSel <= SVM_THR_RST;
      end else begin
         detectorOn   <= enable_reg;
         referenceOn  <= enable_reg;
         thresholdSel <= threshold_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Low supply status
   svm_sync svm_sync_inst (
      .clk_sys (clk_sys),
      .arst_n  (arst_n),
      .asyncIn (cmpBelow),
      .syncOut (cmpSync)
   );

   // Follows the comparator each cycle, so chatter near the level shows
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         lowStatus_reg <= 1'b0;
      end else begin
         lowStatus_reg <= cmpSync & enable_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Delayed interrupt flag
   svm_delay svm_delay_inst (
      .clk_sys (clk_sys),
      .arst_n  (arst_n),
      .run     (lowStatus_reg),
      .expired (delayExpired)
   );

   // Hardware set beats a clear in the same cycle
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         flag_reg <= SVM_FLAG_RST;
      end else if (delayExpired) begin
         flag_reg <= 1'b1;
      end else if (wrForce & avs_writedata[SVM_FLAG_BIT]) begin
         flag_reg <= 1'b1;
      end else if (wrStat & avs_writedata[SVM_FLAG_BIT]) begin
         flag_reg <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         mask_reg <= SVM_MASK_RST;
      end else if (wrMask) begin
         mask_reg <= avs_writedata[SVM_FLAG_BIT];
      end
   end

   // A flag already preset by software gives no wake
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         wakeReq          <= 1'b0;
         lowSupplyIrqFlag <= 1'b0;
         irq              <= 1'b0;
      end else begin
         wakeReq          <= delayExpired & ~flag_reg;
         lowSupplyIrqFlag <= flag_reg;
         irq              <= flag_reg & mask_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!arst_n);

   // Independent count of how long the status has stood high
   logic [SVM_DLY_W-1:0] lowRunCnt_reg;

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         lowRunCnt_reg <= '0;
      end else if (!lowStatus_reg) begin
         lowRunCnt_reg <= '0;
      end else if (lowRunCnt_reg != '1) begin
         lowRunCnt_reg <= lowRunCnt_reg + SVM_DLY_W'(1);
      end
   end

   status_follows_a: assert property (
      ##1 lowStatus_reg == $past(cmpSync & enable_reg))
      else $error("low status does not follow comparator");

   status_falls_a: assert property (
      lowStatus_reg && !cmpSync |=> !lowStatus_reg)
      else $error("low status held after comparator release");

   detector_power_a: assert property (
      wrCtrl |-> ##2 detectorOn == $past(avs_writedata[SVM_EN_BIT], 2))
      else $error("detector power does not match write");

   reference_tied_a: assert property (
      referenceOn == detectorOn)
      else $error("reference not with detector");

   threshold_drive_a: assert property (
      wrCtrl |-> ##2 thresholdSel == $past(avs_writedata[2:0], 2))
      else $error("threshold select not driven");

   no_early_flag_a: assert property (
      $rose(lowStatus_reg) && !flag_reg && !wrForce |=> !flag_reg)
      else $error("flag set without delay");

   flag_after_delay_a: assert property (
      lowStatus_reg [*8] ##0 $rose(delayExpired) |=> flag_reg)
      else $error("flag not set at delay expiry");

   set_beats_clear_a: assert property (
      delayExpired && wrStat |=> flag_reg)
      else $error("clear won over set");

   wake_on_set_a: assert property (
      $rose(flag_reg) && $past(delayExpired) |-> wakeReq)
      else $error("no wake on flag set");

   unused_zero_a: assert property (
      busAck && avs_read |-> avs_readdata[31:6] == '0 && !avs_readdata[3])
      else $error("unused bits not zero");

   bus_answer_a: assert property (
      busReq && avs_waitrequest |=> !avs_waitrequest)
      else $error("answer not in one cycle");

   delay_length_a: assert property (
      delayExpired |-> lowRunCnt_reg == SVM_DLY_W'(SVM_IRQ_DELAY_CYC))
      else $error("flag delay length wrong");

   expire_once_a: assert property (
      delayExpired |=> !delayExpired)
      else $error("delay expiry longer than one cycle");

   flag_no_cause_a: assert property (
      !flag_reg && !delayExpired && !(wrForce && avs_writedata[SVM_FLAG_BIT]) |=> !flag_reg)
      else $error("flag set without cause");

   flag_sticky_a: assert property (
      flag_reg && !(wrStat && avs_writedata[SVM_FLAG_BIT]) |=> flag_reg)
      else $error("flag dropped without clear");

   flag_clear_a: assert property (
      wrStat && avs_writedata[SVM_FLAG_BIT] && !delayExpired |=> !flag_reg)
      else $error("flag not cleared by write");

   flag_copy_a: assert property (
      ##1 lowSupplyIrqFlag == $past(flag_reg))
      else $error("flag output does not follow flag");

   irq_level_a: assert property (
      ##1 irq == $past(flag_reg && mask_reg))
      else $error("interrupt level wrong");

   mask_write_a: assert property (
      wrMask |=> mask_reg == $past(avs_writedata[SVM_FLAG_BIT]))
      else $error("mask write lost");

   force_sets_a: assert property (
      wrForce && avs_writedata[SVM_FLAG_BIT] |=> flag_reg)
      else $error("software preset lost");

   wake_source_a: assert property (
      wakeReq |-> $past(delayExpired) && !$past(flag_reg))
      else $error("wake without hardware flag set");

   wake_pulse_a: assert property (
      wakeReq |=> !wakeReq)
      else $error("wake longer than one cycle");

   disabled_low_a: assert property (
      !enable_reg |=> !lowStatus_reg)
      else $error("status shown while detector off");

   ctrl_write_a: assert property (
      wrCtrl |=> enable_reg == $past(avs_writedata[SVM_EN_BIT]) &&
                 threshold_reg == $past(avs_writedata[SVM_THR_LSB +: SVM_THR_W]))
      else $error("control write lost");

   idle_wait_a: assert property (
      !busReq |=> avs_waitrequest)
      else $error("waitrequest low without request");

   ack_release_a: assert property (
      busAck |=> avs_waitrequest)
      else $error("waitrequest low after answer");

   cover_irq_c:   cover property (flag_reg && mask_reg ##1 irq);
   cover_chat_c:  cover property ($rose(lowStatus_reg) ##[1:20] $fell(lowStatus_reg));
   cover_wake_c:  cover property (wakeReq);
   cover_force_c: cover property (wrForce ##1 flag_reg);

endmodule // svm_top
